// *** verilog/baseband_diff_encoder_fir.v ***
// Baseband symbol path: differential encoders, I/Q mapper and FIR pulse shaper
// Assumes one 100 MHz clock, synchronous inputs and a simple strobe register port
//
// Behaviour
// - Bit-wise encoded bit is current raw bit XOR previous raw bit.
// - With bit-wise encoding on, encoded bits feed the mapper instead of raw.
// - Each symbol moves the state by the signed offset held per data value.
// - State-map encoding works for user I/Q and user FSK mapping alike; the code has no FSK mapping, CTRL_FSK is stored but unused.
// - Bits per symbol is ceiling of log2 of the number of states.
// - Default four-point map uses only plus one and minus one on I and Q.
// - Filters with over 32 symbols or 512 coefficients are not used.
// - Entered oversample ratio 1 to 32, symbols times ratio at most 1024.
// - Operating ratio picked automatically between 4 and 16.
// - Coefficients resampled to operating ratio when entered ratio differs.
// - Mirror copies lower table half reversed into upper half.
// - Oversample ratio is coefficients per symbol, default 4.
// - Offset +1 steps forward, -1 backward, 0 holds the state.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
`include "diff_codec_map.vh"
module baseband_diff_encoder_fir (
	input  wire        clock,
	input  wire        rst,
	input  wire [7:0]  regAddr,
	input  wire [31:0] regWrData,
	input  wire        regWrite,
	input  wire        regRead,
	output reg  [31:0] regRdData,
	input  wire        bitIn,
	input  wire        bitValid,
	output reg         bitReady,
	output reg  [15:0] iOut,
	output reg  [15:0] qOut,
	output reg         iqValid,
	output reg         filterUsable
);
	// ************************************************
	// Registers
	// ************************************************
	reg [3:0]  ctrl_reg;
	reg [4:0]  states_reg;
	reg [5:0]  osrEntered_reg;
	reg [5:0]  filtSymbols_reg;
	reg [15:0] symRate_reg;
	reg [3:0]  offset_reg [0:`STATES_MAX-1];
	reg [7:0]  coef_reg   [0:`TAPS-1];
	reg [15:0] iqMap_reg  [0:`STATES_MAX-1];
	reg        prevBit_reg;
	reg [3:0]  state_reg;
	reg [3:0]  shift_reg;
	reg [2:0]  bitCount_reg;
	reg [15:0] symPipe_reg [0:3];
	reg [4:0]  phase_reg;
	reg        holdSym_reg;
	reg [4:0]  mirrorIdx_reg;
	reg        mirrorBusy_reg;
	integer    k;
	integer    m;
	reg [11:0] tapWide;

	// Base-two ceiling logarithm of the state count
	function [2:0] clog2States;
		input [4:0] n;
		begin
			if (n <= 5'h02) clog2States = 3'h1;
			else if (n <= 5'h04) clog2States = 3'h2;
			else if (n <= 5'h08) clog2States = 3'h3;
			else clog2States = 3'h4;
		end
	endfunction

	// Signed step modulo state count
	function [3:0] wrapStep;
		input [3:0] cur;
		input [3:0] off;
		input [4:0] n;
		reg   [5:0] sum;
		begin
			sum = {2'h0, cur} + {{2{off[3]}}, off} + {1'b0, n};
			if (sum >= {1'b0, n, 1'b0} - 6'h00 && n != 5'h00 && sum >= {1'b0, n} + {1'b0, n})
				sum = sum - {1'b0, n} - {1'b0, n};
			else if (sum >= {1'b0, n})
				sum = sum - {1'b0, n};
			wrapStep = sum[3:0];
		end
	endfunction

	wire [2:0]  bitsPerSym = clog2States(states_reg);
	wire [11:0] coefCount  = filtSymbols_reg * osrEntered_reg;
	wire        osrOk      = (osrEntered_reg >= `OSR_MIN) && (osrEntered_reg <= `OSR_MAX)
	                         && (coefCount <= `PROD_MAX);
	wire        hwOk       = (filtSymbols_reg <= `SYM_MAX) && (coefCount <= `COEF_MAX);
	// Automatic operating ratio: faster symbols or denser symbols get fewer samples
	wire [5:0]  osrOp      = (symRate_reg >= `SYMRATE_FAST || bitsPerSym > 3'h2
	                          || filtSymbols_reg > 6'h10) ? `OSR_OP_MIN : `OSR_OP_MAX;
	wire        encBit     = ctrl_reg[`CTRL_BITDIFF] ? (bitIn ^ prevBit_reg) : bitIn;
	wire [3:0]  symValue   = {shift_reg[2:0], encBit};
	wire        symDone    = (bitCount_reg + 3'h1 == bitsPerSym);
	wire [3:0]  mapIdx     = ctrl_reg[`CTRL_MAPDIFF] ?
	                         wrapStep(state_reg, offset_reg[symValue], states_reg) : symValue;
	wire [31:0] fifoOut;
	wire        fifoValid;
	wire        fifoInReady;
	wire        takeBit    = bitValid && bitReady;

	// ************************************************
	// Register port
	// ************************************************
	always @(posedge clock) begin
		if (rst) begin
			ctrl_reg        <= 4'h0;
			states_reg      <= 5'h04;
			osrEntered_reg  <= `OSR_DEFAULT;
			filtSymbols_reg <= 6'h08;
			symRate_reg     <= 16'h0100;
			regRdData       <= 32'h0;
			mirrorBusy_reg  <= 1'b0;
			mirrorIdx_reg   <= 5'h00;
			for (k = 0; k < `STATES_MAX; k = k + 1) begin
				offset_reg[k] <= 4'h0;
				iqMap_reg[k]  <= 16'h0;
			end
			// Default four-point map with only +1 and -1 components
			iqMap_reg[0] <= {`IQ_PLUS, `IQ_PLUS};
			iqMap_reg[1] <= {`IQ_MINUS, `IQ_PLUS};
			iqMap_reg[2] <= {`IQ_PLUS, `IQ_MINUS};
			iqMap_reg[3] <= {`IQ_MINUS, `IQ_MINUS};
			for (k = 0; k < `TAPS; k = k + 1) begin
				coef_reg[k] <= 8'h00;
			end
		end else begin
			regRdData <= 32'h0;
			if (regWrite) begin
				case (regAddr[7:6])
					2'h0: begin
						if (regAddr == `RA_CTRL) begin
							ctrl_reg <= regWrData[3:0];
							if (regWrData[`CTRL_MIRROR]) begin
								mirrorBusy_reg <= 1'b1;
								mirrorIdx_reg  <= 5'h00;
							end
						end
						if (regAddr == `RA_STATES && regWrData[4:0] >= 5'h02
						    && regWrData[4:0] <= 5'h10)
							states_reg <= regWrData[4:0];
						if (regAddr == `RA_FILTER) begin
							osrEntered_reg  <= regWrData[5:0];
							filtSymbols_reg <= regWrData[13:8];
						end
						if (regAddr == `RA_SYMRATE)
							symRate_reg <= regWrData[15:0];
					end
					2'h1: offset_reg[regAddr[5:2]] <= regWrData[3:0];
					2'h2: coef_reg[regAddr[5:1]] <= regWrData[7:0];
					2'h3: iqMap_reg[regAddr[5:2]] <= regWrData[15:0];
					default: ;
				endcase
			end else if (mirrorBusy_reg) begin
				// Upper half gets lower half reversed, one entry a cycle
				coef_reg[5'd31 - mirrorIdx_reg] <= coef_reg[mirrorIdx_reg];
				mirrorIdx_reg <= mirrorIdx_reg + 5'h01;
				if (mirrorIdx_reg == 5'h0F) begin
					mirrorBusy_reg <= 1'b0;
				end
			end
			if (regRead) begin
				case (regAddr)
					`RA_CTRL:    regRdData <= {28'h0, ctrl_reg};
					`RA_STATES:  regRdData <= {24'h0, bitsPerSym, states_reg};
					`RA_FILTER:  regRdData <= {18'h0, filtSymbols_reg, 2'h0, osrEntered_reg};
					`RA_SYMRATE: regRdData <= {16'h0, symRate_reg};
					`RA_STATUS:  regRdData <= {14'h0, osrOp, 4'h0, state_reg,
					                           prevBit_reg, mirrorBusy_reg, hwOk && osrOk, 1'b0};
					default: begin
						if (regAddr[7:6] == 2'h1)
							regRdData <= {28'h0, offset_reg[regAddr[5:2]]};
						else if (regAddr[7:6] == 2'h2)
							regRdData <= {24'h0, coef_reg[regAddr[5:1]]};
						else if (regAddr[7:6] == 2'h3)
							regRdData <= {16'h0, iqMap_reg[regAddr[5:2]]};
						else
							regRdData <= 32'h0;
					end
				endcase
			end
		end
	end

	// ************************************************
	// Bit intake, encoding and symbol forming
	// ************************************************
	always @(posedge clock) begin
		if (rst) begin
			prevBit_reg  <= 1'b0;
			state_reg    <= 4'h0;
			shift_reg    <= 4'h0;
			bitCount_reg <= 3'h0;
			bitReady     <= 1'b0;
		end else begin
			bitReady <= fifoInReady;
			if (takeBit) begin
				prevBit_reg <= bitIn;
				if (symDone) begin
					bitCount_reg <= 3'h0;
					shift_reg    <= 4'h0;
					if (ctrl_reg[`CTRL_MAPDIFF])
						state_reg <= mapIdx;
				end else begin
					bitCount_reg <= bitCount_reg + 3'h1;
					shift_reg    <= symValue;
				end
			end
		end
	end

	// Mapped symbols queue toward the shaper
	sample_fifo #(.WIDTH(32), .DEPTH(32), .AW(5)) symFifo (
		.clock    (clock),
		.rst      (rst),
		.inData   ({16'h0, iqMap_reg[mapIdx]}),
		.inValid  (takeBit && symDone),
		.inReady  (fifoInReady),
		.outData  (fifoOut),
		.outValid (fifoValid),
		.outReady (!holdSym_reg && fifoValid)
	);

	// ************************************************
	// FIR shaper: operating ratio phases per symbol
	// ************************************************
	reg signed [23:0] accI;
	reg signed [23:0] accQ;
	reg        [4:0]  tap;
	always @* begin
		accI = 24'sh0;
		accQ = 24'sh0;
		tapWide = 12'h000;
		tap = 5'h00;
		for (m = 0; m < 4; m = m + 1) begin
			// Resampled tap index: operating phase scaled to entered ratio, wraps in 32 taps
			tapWide = (({6'h00, phase_reg} * {6'h00, osrEntered_reg}) / {6'h00, osrOp})
			          + ({7'h00, m[4:0]} * {7'h00, osrEntered_reg[4:0]});
			tap = tapWide[4:0];
			accI = accI + $signed(symPipe_reg[m][15:8]) * $signed(coef_reg[tap]);
			accQ = accQ + $signed(symPipe_reg[m][7:0]) * $signed(coef_reg[tap]);
		end
	end

	always @(posedge clock) begin
		if (rst) begin
			phase_reg    <= 5'h00;
			holdSym_reg  <= 1'b0;
			iOut         <= 16'h0;
			qOut         <= 16'h0;
			iqValid      <= 1'b0;
			filterUsable <= 1'b0;
			for (k = 0; k < 4; k = k + 1) begin
				symPipe_reg[k] <= 16'h0;
			end
		end else begin
			filterUsable <= hwOk && osrOk;
			iqValid      <= 1'b0;
			if (fifoValid && !holdSym_reg) begin
				for (k = 3; k > 0; k = k - 1) begin
					symPipe_reg[k] <= symPipe_reg[k-1];
				end
				symPipe_reg[0] <= fifoOut[15:0];
				holdSym_reg    <= 1'b1;
				phase_reg      <= 5'h00;
			end else if (holdSym_reg) begin
				if (hwOk && osrOk) begin
					iOut    <= accI[21:6];
					qOut    <= accQ[21:6];
					iqValid <= 1'b1;
				end
				if ({1'b0, phase_reg} + 6'h01 == osrOp) begin
					holdSym_reg <= 1'b0;
				end else begin
					phase_reg <= phase_reg + 5'h01;
				end
			end
		end
	end
endmodule // baseband_diff_encoder_fir

// *** verilog/diff_codec_map.vh ***
// Register offsets, field positions, reset values and limits of the symbol codec
// Assumes inclusion by bare name from the codec design files
`ifndef DIFF_CODEC_MAP_VH
`define DIFF_CODEC_MAP_VH

// Register word offsets (byte address on the 8-bit port)
`define RA_CTRL        8'h00
`define RA_STATES      8'h04
`define RA_FILTER      8'h08
`define RA_SYMRATE     8'h0C
`define RA_STATUS      8'h10
`define RA_OFFSET_BASE 8'h40
`define RA_COEF_BASE   8'h80
`define RA_IQ_BASE     8'hC0

// Control fields
`define CTRL_BITDIFF   0
`define CTRL_MAPDIFF   1
`define CTRL_MIRROR    2
`define CTRL_FSK       3

// Reset values and limits
`define OSR_DEFAULT    6'h04
`define OSR_MIN        6'h01
`define OSR_MAX        6'h20
`define OSR_OP_MIN     6'h04
`define OSR_OP_MAX     6'h10
`define SYM_MAX        6'h20
`define COEF_MAX       11'h200
`define PROD_MAX       11'h400
`define TAPS           32
`define STATES_MAX     16
`define IQ_PLUS        8'h7F
`define IQ_MINUS       8'h81
`define SYMRATE_FAST   16'h1000

`endif

// *** verilog/sample_fifo.v ***
// Parameterised first-in first-out buffer with valid/ready on both sides
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module sample_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 32,
	parameter AW    = 5
) (
	input  wire             clock,
	input  wire             rst,
	input  wire [WIDTH-1:0] inData,
	input  wire             inValid,
	output wire             inReady,
	output wire [WIDTH-1:0] outData,
	output wire             outValid,
	input  wire             outReady
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW:0]      wrPtr_reg;
	reg [AW:0]      rdPtr_reg;
	wire            full;
	wire            empty;
	wire            doWrite;
	wire            doRead;

	// Full and empty from pointer wrap bit
	assign empty    = (wrPtr_reg == rdPtr_reg);
	assign full     = (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]) && (wrPtr_reg[AW] != rdPtr_reg[AW]);
	assign inReady  = !full;
	assign outValid = !empty;
	assign outData  = mem[rdPtr_reg[AW-1:0]];
	assign doWrite  = inValid && !full;
	assign doRead   = outReady && !empty;

	// Pointer and storage update
	always @(posedge clock) begin
		if (rst) begin
			wrPtr_reg <= {(AW+1){1'b0}};
			rdPtr_reg <= {(AW+1){1'b0}};
		end else begin
			if (doWrite) begin
				wrPtr_reg <= wrPtr_reg + 1'b1;
			end
			if (doRead) begin
				rdPtr_reg <= rdPtr_reg + 1'b1;
			end
		end
		if (doWrite) begin
			mem[wrPtr_reg[AW-1:0]] <= inData;
		end
	end
endmodule // sample_fifo

// *** test/codec_monitor.sv ***
// Checker of the symbol codec ports
// Assumes the codec header, one clock and synchronous active-high reset
`timescale 1ns/100ps
`include "diff_codec_map.vh"
module codec_monitor (
	input wire        clock,
	input wire        rst,
	input wire [7:0]  regAddr,
	input wire [31:0] regWrData,
	input wire        regWrite,
	input wire        regRead,
	input wire [31:0] regRdData,
	input wire        bitValid,
	input wire        bitReady,
	input wire        iqValid,
	input wire        filterUsable
);
	reg bitSeen_reg;
	// Remembers whether any bit was taken since reset
	always @(posedge clock) begin
		if (rst)
			bitSeen_reg <= 1'b0;
		else if (bitValid && bitReady)
			bitSeen_reg <= 1'b1;
	end
	// Ceiling of log2 of a state count
	function automatic [2:0] ceilLog(input [4:0] n);
		ceilLog = (n > 5'h08) ? 3'h4 : (n > 5'h04) ? 3'h3 : (n > 5'h02) ? 3'h2 : 3'h1;
	endfunction
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	a_sym_limit: assert property (regWrite && regAddr == `RA_FILTER
		&& regWrData[13:8] > 6'h20 ##1 !regWrite |-> ##1 !filterUsable)
		else $error("filter over symbol limit usable");
	a_coef_limit: assert property (regWrite && regAddr == `RA_FILTER
		&& regWrData[5:0] * regWrData[13:8] > 12'h200 ##1 !regWrite |-> ##1 !filterUsable)
		else $error("filter over coefficient limit usable");
	a_ratio_range: assert property (regWrite && regAddr == `RA_FILTER
		&& (regWrData[5:0] == 6'h00 || regWrData[5:0] > 6'h20) ##1 !regWrite |-> ##1 !filterUsable)
		else $error("ratio outside range usable");
	a_usable_ok: assert property (regWrite && regAddr == `RA_FILTER && regWrData[5:0] != 6'h00
		&& regWrData[5:0] <= 6'h20
		&& regWrData[13:8] != 6'h00 && regWrData[13:8] <= 6'h20
		&& regWrData[5:0] * regWrData[13:8] <= 12'h200 ##1 !regWrite |-> ##1 filterUsable)
		else $error("legal filter not usable");
	a_unusable_quiet: assert property ((!filterUsable) [*4] |-> !iqValid)
		else $error("samples from unusable filter");
	a_op_ratio: assert property ($past(regRead && regAddr == `RA_STATUS)
		|-> regRdData[17:12] == 6'h04 || regRdData[17:12] == 6'h10)
		else $error("operating ratio outside 4 or 16");
	a_bits_sym: assert property ($past(regRead && regAddr == `RA_STATES)
		|-> regRdData[7:5] == ceilLog(regRdData[4:0]))
		else $error("bits per symbol wrong");
	a_reset_state: assert property ($past(regRead && regAddr == `RA_STATUS && !bitSeen_reg)
		|-> regRdData[7:4] == 4'h0)
		else $error("state not first after reset");
endmodule // codec_monitor

bind baseband_diff_encoder_fir codec_monitor i_mon (.clock(clock), .rst(rst), .regAddr(regAddr),
	.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
	.bitValid(bitValid), .bitReady(bitReady), .iqValid(iqValid), .filterUsable(filterUsable));

// *** test/iq_sink.sv ***
// Converter-side model: takes every shaped sample and counts them
// Assumes samples are offered by a one-cycle valid pulse
`timescale 1ns/100ps
module iq_sink (
	input wire        clock,
	input wire        rst,
	input wire [15:0] iOut,
	input wire [15:0] qOut,
	input wire        iqValid,
	output reg [15:0] sampleCount,
	output reg [31:0] lastPair
);
	// Count samples and keep the last pair
	always @(posedge clock) begin
		if (rst) begin
			sampleCount <= 16'h0000;
			lastPair <= 32'h00000000;
		end else if (iqValid) begin
			sampleCount <= sampleCount + 16'h0001;
			lastPair <= {iOut, qOut};
		end
	end
endmodule // iq_sink

// *** test/baseband_diff_encoder_fir_bench.sv ***
// Self-checking bench of the symbol codec
// Assumes the codec header, the checker and the converter-side model
`timescale 1ns/100ps
`include "diff_codec_map.vh"
module baseband_diff_encoder_fir_bench;
	reg         clock;
	reg         rst;
	reg  [7:0]  regAddr;
	reg  [31:0] regWrData;
	reg         regWrite;
	reg         regRead;
	wire [31:0] regRdData;
	reg         bitIn;
	reg         bitValid;
	wire        bitReady;
	wire [15:0] iOut;
	wire [15:0] qOut;
	wire        iqValid;
	wire        filterUsable;
	wire [15:0] sampleCount;
	wire [31:0] lastPair;
	integer     mismatches;
	integer     testsRun;
	integer     cycles;
	integer     i;
	integer     state;
	integer     off [0:3];
	reg  [1:0]  sym;
	reg  [31:0] d;
	baseband_diff_encoder_fir i_dut (.clock(clock), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
		.bitIn(bitIn), .bitValid(bitValid), .bitReady(bitReady), .iOut(iOut), .qOut(qOut),
		.iqValid(iqValid), .filterUsable(filterUsable));
	iq_sink i_sink (.clock(clock), .rst(rst), .iOut(iOut), .qOut(qOut), .iqValid(iqValid),
		.sampleCount(sampleCount), .lastPair(lastPair));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	task chk(input [31:0] seen, input [31:0] exp, input string what);
		testsRun = testsRun + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("mismatch %0s expected %h seen %h", what, exp, seen);
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		@(posedge clock);
		regWrite <= 1'b1;
		regAddr <= a;
		regWrData <= v;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task rd(input [7:0] a);
		@(posedge clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clock);
		regRead <= 1'b0;
		#1 d = regRdData;
	endtask
	task filt(input [31:0] v, input [31:0] u);
		wr(`RA_FILTER, v);
		repeat (3) @(posedge clock);
		chk(filterUsable, u, "usable");
	endtask
	task setMap(input [31:0] ctrl);
		for (i = 0; i < 4; i = i + 1)
			wr(`RA_OFFSET_BASE + {i[5:0], 2'b00}, {28'h0000000, off[i][3:0]});
		wr(`RA_CTRL, ctrl);
	endtask
	// Streams 0011100001 and follows the state by the offset table
	task runStream(input diff);
		reg raw;
		reg enc;
		reg prevRaw;
		prevRaw = 1'b0;
		state = 0;
		for (i = 0; i < 10; i = i + 1) begin
			raw = 10'h0E1 >> (9 - i);
			enc = diff ? raw ^ prevRaw : raw;
			prevRaw = raw;
			sym = {sym[0], enc};
			if (i % 2 == 1)
				state = (state + off[sym] + 4) % 4;
			@(posedge clock);
			bitValid <= 1'b1;
			bitIn <= raw;
			@(posedge clock);
			while (!bitReady) @(posedge clock);
			bitValid <= 1'b0;
			bitIn <= ~raw;
		end
		while (sampleCount < 16'h0050) @(posedge clock);
		rd(`RA_STATUS);
		chk(d[7:4], state, "state");
		chk(sampleCount, 32'h50, "samples");
	endtask
	task closeOut;
		$display("checks %0d mismatches %0d", testsRun, mismatches);
		if (mismatches == 0 && testsRun > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			mismatches = mismatches + 1;
			closeOut;
		end
	end
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{rst, regWrite, regRead, bitIn, bitValid} = 5'h10;
		{regAddr, regWrData, mismatches, testsRun, cycles, sym} = 0;
		off[0] = 1;
		off[1] = -1;
		off[2] = 2;
		off[3] = 0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		rd(`RA_FILTER);
		chk(d, 32'h00000804, "filter");
		rd(`RA_STATES);
		chk(d, 32'h00000044, "states");
		rd(8'h20);
		chk(d, 32'h0, "unmapped");
		rd(`RA_STATUS);
		chk(d[17:12], 32'h10, "opratio");
		for (i = 0; i < 4; i = i + 1) begin
			rd(`RA_IQ_BASE + {i[5:0], 2'b00});
			chk((d[15:8] == 8'h7F || d[15:8] == 8'h81) && (d[7:0] == 8'h7F || d[7:0] == 8'h81), 1, "iqmap");
		end
		for (i = 0; i < 16; i = i + 1)
			wr(`RA_COEF_BASE + {i[6:0], 1'b0}, i + 1);
		wr(`RA_CTRL, 32'h4);
		repeat (20) @(posedge clock);
		for (i = 16; i < 32; i = i + 1) begin
			rd(`RA_COEF_BASE + {i[6:0], 1'b0});
			chk(d[7:0], 32 - i, "coef");
		end
		filt(32'h2108, 0);
		filt(32'h2011, 0);
		filt(32'h2010, 1);
		filt(32'h0800, 0);
		filt(32'h0821, 0);
		filt(32'h0120, 1);
		filt(32'h0804, 1);
		setMap(32'h2);
		runStream(1'b0);
		rst <= 1'b1;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		setMap(32'hB);
		runStream(1'b1);
		chk(lastPair, 32'h0, "pair");
		wr(`RA_SYMRATE, 32'h1000);
		rd(`RA_STATUS);
		chk(d[17:12], 32'h4, "opratio");
		wr(`RA_STATES, 32'h5);
		wr(`RA_STATES, 32'h11);
		rd(`RA_STATES);
		chk(d[7:0], 32'h65, "states");
		closeOut;
	end
endmodule // baseband_diff_encoder_fir_bench
